/* File: hdl/expansion_port_mapping.v */
// Expansion port mapping: register slave, mode decode and pin steering
`timescale 1ns/100ps
`include "expansion_port_defs.vh"
module expansion_port_mapping #(
	parameter WIDTH = 8
) (
	input  wire              clock,
	input  wire              srst,
	// AXI4-Lite slave
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// Internal core access
	input  wire              coreValid,
	input  wire [15:0]       coreAddr,
	input  wire              coreWrite,
	input  wire              coreWord,
	input  wire [15:0]       coreWdata,
	input  wire              coreInternal,
	input  wire              coreRam,
	output reg               busStrobeLow,
	output reg               busAddr0,
	output reg               busReadWrite,
	output reg               busCycle,
	output reg               busSecondByte,
	// Pins, output enable low while driving
	input  wire [WIDTH-1:0]  portAIn,
	output reg  [WIDTH-1:0]  portAOut,
	output reg  [WIDTH-1:0]  portAOe,
	input  wire [WIDTH-1:0]  portBIn,
	output reg  [WIDTH-1:0]  portBOut,
	output reg  [WIDTH-1:0]  portBOe,
	input  wire [WIDTH-1:0]  portCIn,
	output reg  [WIDTH-1:0]  portCOut,
	output reg  [WIDTH-1:0]  portCOe,
	input  wire [WIDTH-1:0]  portDIn,
	output reg  [WIDTH-1:0]  portDOut,
	output reg  [WIDTH-1:0]  portDOe,
	input  wire [WIDTH-1:0]  portEIn,
	output reg  [WIDTH-1:0]  portEOut,
	output reg  [WIDTH-1:0]  portEOe,
	input  wire              eClockIn,
	output reg  [WIDTH-1:0]  portEPullup,
	output reg               auxResetOut
);
// ==========================================
// Registers and mode decode
reg [7:0] highAddrData;
reg [7:0] highAddrDir;
reg [7:0] lowAddrData;
reg [7:0] lowAddrDir;
reg [7:0] highDataData;
reg [7:0] highDataDir;
reg [7:0] lowDataData;
reg [7:0] lowDataDir;
reg [7:0] ctrlData;
reg [7:0] ctrlDir;
reg [7:0] funcSelect;
reg [6:0] modeReg;
reg [15:0] extData;
reg [7:0] syncA1, syncA2, syncA3, inA;
reg [7:0] syncB1, syncB2, syncB3, inB;
reg [7:0] syncC1, syncC2, syncC3, inC;
reg [7:0] syncD1, syncD2, syncD3, inD;
reg [7:0] syncE1, syncE2, syncE3, inE;
wire [2:0] mode = modeReg[`MODE_SEL_HI:`MODE_SEL_LO];
wire special = ~mode[2];
wire periph = (mode == `MODE_SPEC_PERIPH);
wire single = (mode == `MODE_SPEC_SINGLE) | (mode == `MODE_NORM_SINGLE);
wire expanded = ~single & ~periph;
wire wide = (mode == `MODE_SPEC_WIDE) | (mode == `MODE_NORM_WIDE);
wire narrow = expanded & ~wide;
wire specNarrow = (mode == `MODE_SPEC_NARROW);
wire data_low_port_emulate = modeReg[`MODE_EMD_BIT];
wire control_port_emulate = modeReg[`MODE_EME_BIT];
wire abcMapped = single;
wire dEmul = specNarrow & data_low_port_emulate;
wire dMapped = ~(wide | periph | dEmul);
wire eMapped = ~(periph | (expanded & control_port_emulate));
wire selMapped = ~periph;
wire visWide = dEmul & modeReg[`MODE_VIS_BIT];
// ==========================================
// Bus write path
reg awHeld, wHeld;
reg [7:0] awAddr;
reg [31:0] wData;
reg [3:0] wStrb;
assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
wire wr0 = wStrb[0];
function mapped;
	input [7:0] a;
	begin
		case (a)
			`REG_HIGH_ADDR_DATA, `REG_LOW_ADDR_DATA, `REG_HIGH_ADDR_DIR, `REG_LOW_ADDR_DIR,
			`REG_HIGH_DATA_DATA, `REG_HIGH_DATA_DIR: mapped = abcMapped;
			`REG_LOW_DATA_DATA, `REG_LOW_DATA_DIR: mapped = dMapped;
			`REG_CTRL_DATA, `REG_CTRL_DIR: mapped = eMapped;
			`REG_FUNC_SELECT: mapped = selMapped;
			`REG_MODE, `REG_STATUS, `REG_EXT_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
endfunction
wire wrOk = mapped(awAddr);
always @(posedge clock) begin
	if (srst) begin
		awHeld <= 1'b0;
		wHeld <= 1'b0;
		awAddr <= `RST_BYTE;
		wData <= {`ZERO16, `ZERO16};
		wStrb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `AXI_OKAY;
		highAddrData <= `RST_BYTE;
		highAddrDir <= `RST_BYTE;
		lowAddrData <= `RST_BYTE;
		lowAddrDir <= `RST_BYTE;
		highDataData <= `RST_BYTE;
		highDataDir <= `RST_BYTE;
		lowDataData <= `RST_BYTE;
		lowDataDir <= `RST_BYTE;
		ctrlData <= `RST_BYTE;
		ctrlDir <= `RST_BYTE;
		funcSelect <= `RST_BYTE;
		modeReg <= `RST_MODE;
	end else begin
		if (s_axi_awvalid & s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end
		if (doWrite) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrOk ? `AXI_OKAY : `AXI_SLVERR;
			if (wrOk & wr0) begin
				case (awAddr)
					`REG_HIGH_ADDR_DATA: highAddrData <= wData[7:0];
					`REG_LOW_ADDR_DATA: lowAddrData <= wData[7:0];
					`REG_HIGH_ADDR_DIR: highAddrDir <= wData[7:0];
					`REG_LOW_ADDR_DIR: lowAddrDir <= wData[7:0];
					`REG_HIGH_DATA_DATA: highDataData <= wData[7:0];
					`REG_LOW_DATA_DATA: lowDataData <= wData[7:0];
					`REG_HIGH_DATA_DIR: highDataDir <= wData[7:0];
					`REG_LOW_DATA_DIR: lowDataDir <= wData[7:0];
					`REG_CTRL_DATA: ctrlData <= wData[7:0];
					`REG_CTRL_DIR: ctrlDir <= wData[7:0];
					`REG_FUNC_SELECT: funcSelect <= wData[7:0];
					`REG_MODE: modeReg <= wData[6:0];
					default: modeReg <= modeReg;
				endcase
			end
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end
// ==========================================
// Bus read path
assign s_axi_arready = ~s_axi_rvalid;
reg [7:0] rdByte;
always @* begin
	rdByte = `RST_BYTE;
	case (s_axi_araddr)
		`REG_HIGH_ADDR_DATA: rdByte = (highAddrDir & highAddrData) | (~highAddrDir & inA);
		`REG_LOW_ADDR_DATA: rdByte = (lowAddrDir & lowAddrData) | (~lowAddrDir & inB);
		`REG_HIGH_ADDR_DIR: rdByte = highAddrDir;
		`REG_LOW_ADDR_DIR: rdByte = lowAddrDir;
		`REG_HIGH_DATA_DATA: rdByte = (highDataDir & highDataData) | (~highDataDir & inC);
		`REG_LOW_DATA_DATA: rdByte = (lowDataDir & lowDataData) | (~lowDataDir & inD);
		`REG_HIGH_DATA_DIR: rdByte = highDataDir;
		`REG_LOW_DATA_DIR: rdByte = lowDataDir;
		`REG_CTRL_DATA: rdByte = (ctrlDir & ctrlData) | (~ctrlDir & inE);
		`REG_CTRL_DIR: rdByte = ctrlDir;
		`REG_FUNC_SELECT: rdByte = funcSelect;
		`REG_MODE: rdByte = {1'b0, modeReg};
		`REG_STATUS: rdByte = {3'h0, visWide, selMapped, eMapped, dMapped, abcMapped};
		default: rdByte = `RST_BYTE;
	endcase
end
always @(posedge clock) begin
	if (srst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= {`ZERO16, `ZERO16};
		s_axi_rresp <= `AXI_OKAY;
	end else if (s_axi_arvalid & s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		// Unmapped registers answer with zero data
		if (~mapped(s_axi_araddr))
			s_axi_rdata <= {`ZERO16, `ZERO16};
		else if (s_axi_araddr == `REG_EXT_DATA)
			s_axi_rdata <= {`ZERO16, extData};
		else
			s_axi_rdata <= {`ZERO24, rdByte};
		s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end
// ==========================================
// Pin synchronisers
always @(posedge clock) begin
	if (srst) begin
		{syncA1, syncA2, syncA3, inA} <= {`ZERO16, `ZERO16};
		{syncB1, syncB2, syncB3, inB} <= {`ZERO16, `ZERO16};
		{syncC1, syncC2, syncC3, inC} <= {`ZERO16, `ZERO16};
		{syncD1, syncD2, syncD3, inD} <= {`ZERO16, `ZERO16};
		{syncE1, syncE2, syncE3, inE} <= {`ZERO16, `ZERO16};
	end else begin
		{syncA1, syncA2, syncA3} <= {portAIn[7:0], syncA1, syncA2};
		{syncB1, syncB2, syncB3} <= {portBIn[7:0], syncB1, syncB2};
		{syncC1, syncC2, syncC3} <= {portCIn[7:0], syncC1, syncC2};
		{syncD1, syncD2, syncD3} <= {portDIn[7:0], syncD1, syncD2};
		{syncE1, syncE2, syncE3} <= {portEIn[7:0], syncE1, syncE2};
		inA <= (~(syncA2 ^ syncA3) & syncA3) | ((syncA2 ^ syncA3) & inA);
		inB <= (~(syncB2 ^ syncB3) & syncB3) | ((syncB2 ^ syncB3) & inB);
		inC <= (~(syncC2 ^ syncC3) & syncC3) | ((syncC2 ^ syncC3) & inC);
		inD <= (~(syncD2 ^ syncD3) & syncD3) | ((syncD2 ^ syncD3) & inD);
		inE <= (~(syncE2 ^ syncE3) & syncE3) | ((syncE2 ^ syncE3) & inE);
	end
end
// ==========================================
// External bus cycle sequencer
localparam S_IDLE = 3'h1;
localparam S_HIGH = 3'h2;
localparam S_LOW  = 3'h4;
reg [2:0] state;
reg [15:0] cycAddr;
reg [15:0] cycData;
reg cycWrite, cycWord, cycVis;
// Launch values: pins take what the sequencer loads at the same edge,
// so address, data and control stand for each byte while busCycle is high
wire accept = (state == S_IDLE) & coreValid & ~single & (~coreInternal | modeReg[`MODE_VIS_BIT]);
wire [15:0] loadAddr = {coreAddr[15:1], coreAddr[0] & (~coreWord | coreRam)};
wire oddRamWord = coreWord & coreRam & coreAddr[0];
wire [15:0] loadData = oddRamWord ? {coreWdata[7:0], coreWdata[15:8]} : coreWdata;
wire loadA0 = coreWord ? (coreAddr[0] & coreRam) : coreAddr[0];
wire loadStrobe = coreWord ? (coreAddr[0] & coreRam) : ~coreAddr[0];
wire splitNow = (state == S_HIGH) & narrow & cycWord & ~(cycVis & visWide);
wire pinCycle = accept | splitNow;
wire pinWrite = accept ? coreWrite : cycWrite;
wire pinVis = accept ? coreInternal : cycVis;
wire pinDrive = pinCycle & pinWrite;
wire pinStrobe = accept ? loadStrobe : (busStrobeLow & ~splitNow);
wire [15:0] pinAddr = accept ? loadAddr : cycAddr;
wire [15:0] pinData = accept ? loadData : cycData;
always @(posedge clock) begin
	if (srst) begin
		state <= S_IDLE;
		cycAddr <= `ZERO16;
		cycData <= `ZERO16;
		cycWrite <= 1'b0;
		cycWord <= 1'b0;
		cycVis <= 1'b0;
		extData <= `ZERO16;
		busStrobeLow <= 1'b1;
		busAddr0 <= 1'b0;
		busReadWrite <= 1'b1;
		busCycle <= 1'b0;
		busSecondByte <= 1'b0;
	end else begin
		case (state)
			S_IDLE: begin
				busCycle <= 1'b0;
				busSecondByte <= 1'b0;
				if (accept) begin
					cycAddr <= loadAddr;
					cycWrite <= coreWrite;
					cycWord <= coreWord;
					cycVis <= coreInternal;
					cycData <= loadData;
					busCycle <= 1'b1;
					busReadWrite <= ~coreWrite;
					busAddr0 <= loadA0;
					busStrobeLow <= loadStrobe;
					state <= S_HIGH;
				end
			end
			S_HIGH: begin
				if (cycWrite == 1'b0)
					extData[15:8] <= inC;
				if (splitNow) begin
					busSecondByte <= 1'b1;
					busAddr0 <= 1'b1;
					busStrobeLow <= 1'b0;
					state <= S_LOW;
				end else begin
					if (cycWrite == 1'b0)
						extData[7:0] <= (wide | visWide) ? inD : inC;
					busCycle <= 1'b0;
					state <= S_IDLE;
				end
			end
			S_LOW: begin
				if (cycWrite == 1'b0)
					extData[7:0] <= inC;
				busCycle <= 1'b0;
				busSecondByte <= 1'b0;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
		endcase
	end
end
// ==========================================
// Pin steering
wire busAB = expanded | periph;
wire busC = expanded | periph;
wire busD = wide | periph | dEmul;
always @(posedge clock) begin
	if (srst) begin
		portAOut <= `RST_BYTE;
		portAOe <= 8'hff;
		portBOut <= `RST_BYTE;
		portBOe <= 8'hff;
		portCOut <= `RST_BYTE;
		portCOe <= 8'hff;
		portDOut <= `RST_BYTE;
		portDOe <= 8'hff;
		portEOut <= `RST_BYTE;
		portEOe <= 8'hff;
		portEPullup <= `RST_BYTE;
		auxResetOut <= 1'b0;
	end else begin
		portAOut <= busAB ? pinAddr[15:8] : highAddrData;
		portAOe <= busAB ? 8'h00 : ~highAddrDir;
		portBOut <= busAB ? pinAddr[7:0] : lowAddrData;
		portBOe <= busAB ? 8'h00 : ~lowAddrDir;
		portCOut <= busC ? (splitNow ? pinData[7:0] : pinData[15:8]) : highDataData;
		portCOe <= busC ? {8{~pinDrive}} : ~highDataDir;
		portDOut <= busD ? pinData[7:0] : lowDataData;
		portDOe <= busD ? {8{~(pinDrive & (wide | periph | pinVis))}} : ~lowDataDir;
		// bus control on port E when selected (strobe and read/write only in expanded modes), else general-purpose on pins 7:2; pins 1:0 always released
		portEOut[7:5] <= ctrlData[7:5];
		portEOut[4] <= funcSelect[`FS_NECLK_BIT] ? ctrlData[4] : pinCycle;
		portEOut[3] <= (funcSelect[`FS_STRB_BIT] & expanded) ? pinStrobe : ctrlData[3];
		portEOut[2] <= (funcSelect[`FS_RDW_BIT] & expanded) ? ~pinWrite : ctrlData[2];
		portEOut[1:0] <= 2'h0;
		portEOe[7] <= funcSelect[`FS_AUX_RESET_IN_BIT] | ~ctrlDir[7];
		portEOe[6:5] <= (funcSelect[`FS_PIPE_BIT] & ~single) ? 2'h0 : ~ctrlDir[6:5];
		portEOe[4] <= funcSelect[`FS_NECLK_BIT] ? ~ctrlDir[4] : periph;
		portEOe[3] <= (funcSelect[`FS_STRB_BIT] & expanded) ? 1'b0 : ~ctrlDir[3];
		portEOe[2] <= (funcSelect[`FS_RDW_BIT] & expanded) ? 1'b0 : ~ctrlDir[2];
		portEOe[1:0] <= 2'h3;
		// shared pullup on strobe, read/write and nonmaskable pins; maskable always
		portEPullup[7:4] <= 4'h0;
		portEPullup[3:2] <= portEOe[3:2] & {2{modeReg[`MODE_PUPE_BIT]}};
		portEPullup[1] <= 1'b1;
		portEPullup[0] <= modeReg[`MODE_PUPE_BIT];
		auxResetOut <= funcSelect[`FS_AUX_RESET_IN_BIT] & inE[7];
	end
end
endmodule // expansion_port_mapping

/* File: pkg/expansion_port_defs.vh */
// Constants for the expansion port mapping block
`ifndef EXPANSION_PORT_DEFS_VH
`define EXPANSION_PORT_DEFS_VH
// Register byte offsets
`define REG_HIGH_ADDR_DATA   8'h00
`define REG_LOW_ADDR_DATA    8'h04
`define REG_HIGH_ADDR_DIR    8'h08
`define REG_LOW_ADDR_DIR     8'h0c
`define REG_HIGH_DATA_DATA   8'h10
`define REG_LOW_DATA_DATA    8'h14
`define REG_HIGH_DATA_DIR    8'h18
`define REG_LOW_DATA_DIR     8'h1c
`define REG_CTRL_DATA        8'h20
`define REG_CTRL_DIR         8'h24
`define REG_FUNC_SELECT      8'h28
`define REG_MODE             8'h2c
`define REG_STATUS           8'h30
`define REG_EXT_DATA         8'h34
// Mode codes, {special_n, b, a}
`define MODE_SPEC_SINGLE     3'h0
`define MODE_SPEC_NARROW     3'h1
`define MODE_SPEC_PERIPH     3'h2
`define MODE_SPEC_WIDE       3'h3
`define MODE_NORM_SINGLE     3'h4
`define MODE_NORM_NARROW     3'h5
`define MODE_NORM_WIDE       3'h7
// Mode register fields
`define MODE_SEL_HI          6
`define MODE_SEL_LO          4
`define MODE_VIS_BIT         3
`define MODE_PUPE_BIT        2
`define MODE_EMD_BIT         1
`define MODE_EME_BIT         0
// Function select fields
`define FS_AUX_RESET_IN_BIT          7
`define FS_PIPE_BIT          5
`define FS_NECLK_BIT         4
`define FS_STRB_BIT          3
`define FS_RDW_BIT           2
// Reset values and misc
`define RST_BYTE             8'h00
`define RST_MODE             7'h00
`define AXI_OKAY             2'h0
`define AXI_SLVERR           2'h2
`define ZERO24               24'h000000
`define ZERO16               16'h0000
`endif

/* File: sim/expansion_port_mapping_chk.sv */
// Checker for bus strobes, address pins and response holding
`timescale 1ns/100ps
module expansion_port_mapping_chk #(
	parameter WIDTH = 8
) (
	input wire logic             clock,
	input wire logic             srst,
	input wire logic [15:0]      coreAddr,
	input wire logic             coreWrite,
	input wire logic             coreWord,
	input wire logic             coreRam,
	input wire logic             busStrobeLow,
	input wire logic             busAddr0,
	input wire logic             busReadWrite,
	input wire logic             busCycle,
	input wire logic             busSecondByte,
	input wire logic [WIDTH-1:0] portAOut,
	input wire logic [WIDTH-1:0] portAOe,
	input wire logic [WIDTH-1:0] portBOut,
	input wire logic [WIDTH-1:0] portBOe,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [31:0]      s_axi_rdata
);
	// ==========================================
	// Properties
	wire addrLsb = coreAddr[0];
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	property p_byte_lane;
		$rose(busCycle) && !$past(coreWord) |-> busStrobeLow != busAddr0 && busAddr0 == $past(addrLsb);
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("byte lane code wrong");
	property p_word_even;
		$rose(busCycle) && $past(coreWord) && !$past(addrLsb) |-> !busStrobeLow && !busAddr0;
	endproperty
	a_word_even: assert property (p_word_even) else $error("aligned word code wrong");
	property p_odd_ram;
		$rose(busCycle) && !$past(coreRam) |-> !(busStrobeLow && busAddr0);
	endproperty
	a_odd_ram: assert property (p_odd_ram) else $error("misaligned code outside ram");
	property p_dir;
		$rose(busCycle) |-> busReadWrite == !$past(coreWrite);
	endproperty
	a_dir: assert property (p_dir) else $error("read write line wrong");
	property p_addr_pins;
		$rose(busCycle) |-> {portAOut, portBOut} == $past(coreAddr) && portAOe == 0 && portBOe == 0;
	endproperty
	a_addr_pins: assert property (p_addr_pins) else $error("address pins wrong");
	property p_second;
		$rose(busSecondByte) |-> $past(busCycle) && busCycle ##1 !busSecondByte;
	endproperty
	a_second: assert property (p_second) else $error("second byte cycle wrong");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	c_split: cover property ($rose(busSecondByte));
	c_ram_odd: cover property (busCycle && busStrobeLow && busAddr0);
	c_write: cover property ($rose(busCycle) && !busReadWrite);
endmodule // expansion_port_mapping_chk

bind expansion_port_mapping expansion_port_mapping_chk #(.WIDTH(WIDTH)) i_chk (.*);

/* File: sim/expansion_port_mapping_tb.sv */
// Testbench for the expansion port mapping block
`timescale 1ns/100ps
`include "expansion_port_defs.vh"
module expansion_port_mapping_tb;
	// ==========================================
	// Signals
	logic        clock = 0, srst = 1, eClockIn = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, rd;
	logic [3:0]  s_axi_wstrb = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	logic        coreValid = 0, coreWrite = 0, coreWord = 0, coreInternal = 0, coreRam = 0, sec;
	logic [15:0] coreAddr = 0, coreWdata = 0;
	wire         busStrobeLow, busAddr0, busReadWrite, busCycle, busSecondByte, auxResetOut;
	wire [7:0]   portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, portCIn, portCOut, portCOe;
	wire [7:0]   portDIn, portDOut, portDOe, portEIn, portEOut, portEOe, portEPullup;
	logic [1:0]  resp;
	logic [2:0]  seen;
	logic [7:0]  pc, pd;
	int          n_errors = 0, checks_done = 0, i;
	always #12.5 clock = ~clock;
	expansion_port_mapping i_dut (.*);
	port_far_side i_far (.*);
	// ==========================================
	// Tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic aw, wd, ar, bk;
		bk = 0;
		if (w) begin
			s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'h1;
			s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		end else begin
			s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		end
		while (!bk) begin
			@(negedge clock);
			aw = s_axi_awready; wd = s_axi_wready; ar = s_axi_arready;
			bk = w ? s_axi_bvalid : s_axi_rvalid;
			resp = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge clock);
			if (w && aw) s_axi_awvalid <= 0;
			if (w && wd) s_axi_wvalid <= 0;
			if (!w && ar) s_axi_arvalid <= 0;
			if (bk) begin
				s_axi_bready <= 0; s_axi_rready <= 0;
			end
		end
		@(posedge clock);
	endtask
	task set_mode(input logic [31:0] m);
		acc(1, `REG_MODE, m);
		acc(1, `REG_MODE, m);
	endtask
	task core(input logic [15:0] a, input logic wr, wd, in, ram, input logic [15:0] d);
		coreAddr <= a; coreWrite <= wr; coreWord <= wd; coreInternal <= in; coreRam <= ram;
		coreWdata <= d; coreValid <= 1; sec = 0; seen = 3'h7;
		@(posedge clock);
		coreValid <= 0;
		repeat (5) begin
			@(negedge clock);
			if (busCycle) break;
		end
		seen = {busStrobeLow, busAddr0, busReadWrite}; pc = portCOut; pd = portDOut;
		repeat (3) begin
			@(negedge clock);
			sec = sec | busSecondByte;
		end
		@(posedge clock);
	endtask
	// ==========================================
	// Tests
	initial begin
		#(25 * 20000);
		n_errors++;
		final_report;
	end
	initial begin
		repeat (10) @(posedge clock);
		srst <= 0;
		acc(0, `REG_HIGH_ADDR_DIR, 0);
		check(resp, `AXI_OKAY);
		check(rd, 0);
		check(portAOe, 8'hff);
		check(portEPullup, 8'h02);
		acc(1, `REG_HIGH_ADDR_DIR, 32'h0f);
		acc(1, `REG_HIGH_ADDR_DATA, 32'h5a);
		acc(0, `REG_HIGH_ADDR_DIR, 0);
		check(rd, 32'h0f);
		check(portAOe, 8'hf0);
		check(portAOut[3:0], 4'ha);
		acc(0, 8'h3c, 0);
		check(resp, `AXI_SLVERR);
		set_mode(32'h04);
		check(portEPullup, 8'h0f);
		// Special narrow, visibility on, no emulation
		set_mode(32'h18);
		for (i = 0; i < 6; i++) begin
			acc(0, 8'h00 + 8'(i) * 8'h04 + ((i > 4) ? 8'h04 : 8'h00), 0);
			check(resp, `AXI_SLVERR);
			if (i == 2) check(rd, 0);
		end
		acc(0, `REG_LOW_DATA_DATA, 0);
		check(resp, `AXI_OKAY);
		acc(0, `REG_CTRL_DATA, 0);
		check(resp, `AXI_OKAY);
		acc(1, `REG_FUNC_SELECT, 32'h0c);
		check(portEOe[3:2], 2'h0);
		for (i = 0; i < 8; i++) begin
			if (i == 3 || i == 7) continue;
			core(16'h2200 + i[0], i[2], i[1], 1'b0, 1'b0, 16'h0000);
			check(seen, {!i[1] && !i[0], i[0], !i[2]});
			check(sec, i[1]);
		end
		// Special narrow with both emulate bits
		set_mode(32'h1b);
		acc(0, `REG_LOW_DATA_DIR, 0);
		check(resp, `AXI_SLVERR);
		acc(0, `REG_CTRL_DATA, 0);
		check(resp, `AXI_SLVERR);
		acc(0, `REG_STATUS, 0);
		check(rd, 32'h18);
		core(16'h0802, 1'b1, 1'b1, 1'b1, 1'b0, 16'hc3a5);
		check(pc, 8'hc3);
		check(pd, 8'ha5);
		check(sec, 0);
		core(16'h0803, 1'b1, 1'b1, 1'b1, 1'b1, 16'hc3a5);
		check(seen[2:1], 2'h3);
		check(pc, 8'ha5);
		check(pd, 8'hc3);
		// Special wide, special peripheral, then normal narrow with port D emulate set
		set_mode(32'h30);
		acc(0, `REG_LOW_DATA_DATA, 0);
		check(resp, `AXI_SLVERR);
		acc(0, `REG_CTRL_DIR, 0);
		check(resp, `AXI_OKAY);
		set_mode(32'h20);
		acc(0, `REG_FUNC_SELECT, 0);
		check(resp, `AXI_SLVERR);
		acc(0, `REG_LOW_DATA_DIR, 0);
		check(resp, `AXI_SLVERR);
		acc(0, `REG_CTRL_DIR, 0);
		check(resp, `AXI_SLVERR);
		set_mode(32'h52);
		acc(0, `REG_LOW_DATA_DATA, 0);
		check(resp, `AXI_OKAY);
		final_report;
	end
endmodule // expansion_port_mapping_tb

/* File: sim/port_far_side.sv */
// Far-side model: pin levels and external port replacement store
`timescale 1ns/100ps
module port_far_side (
	input wire logic        clock,
	input wire logic        busCycle,
	input wire logic        busReadWrite,
	input wire logic [7:0]  portAOut,
	input wire logic [7:0]  portAOe,
	input wire logic [7:0]  portBOut,
	input wire logic [7:0]  portBOe,
	input wire logic [7:0]  portCOut,
	input wire logic [7:0]  portCOe,
	input wire logic [7:0]  portDOut,
	input wire logic [7:0]  portDOe,
	input wire logic [7:0]  portEOut,
	input wire logic [7:0]  portEOe,
	input wire logic [7:0]  portEPullup,
	output wire logic [7:0] portAIn,
	output wire logic [7:0] portBIn,
	output wire logic [7:0] portCIn,
	output wire logic [7:0] portDIn,
	output wire logic [7:0] portEIn
);
	logic [7:0] mem [0:255];
	logic [7:0] lastA = 8'h00, lastB = 8'h00, lastC = 8'h00, lastD = 8'h00, lastE = 8'h00;
	// Released lines flip every cycle except port C in read cycles, pulled-up lines sit high
	assign portAIn = portAOut & ~portAOe | ~lastA & portAOe;
	assign portBIn = portBOut & ~portBOe | ~lastB & portBOe;
	assign portCIn = (busCycle && busReadWrite) ? mem[portBOut] : portCOut & ~portCOe | ~lastC & portCOe;
	assign portDIn = portDOut & ~portDOe | ~lastD & portDOe;
	assign portEIn = portEOut & ~portEOe | (portEPullup | ~lastE) & portEOe;
	always @(posedge clock) begin
		{lastA, lastB, lastC, lastD, lastE} <= {portAIn, portBIn, portCIn, portDIn, portEIn};
		if (busCycle && !busReadWrite)
			mem[portBOut] <= portCOut;
	end
endmodule // port_far_side
